//--- hdl/dprm_pkg.sv
// Purpose: shared constants and types for the dual-port ram host controller
// Assumes: one 20 MHz clock, device pins sampled as synchronous inputs
// Notes:   all pin timing figures are in ns and turned into whole cycles here
package dprm_pkg;

  // clock period of the controller
  localparam int CLK_PERIOD_NS        = 50;

  // pin timing figures in ns; defaults match the slowest speed grade
  localparam int SELECT_ACCESS_NS     = 20;
  localparam int OE_ACCESS_NS         = 12;
  localparam int FLOWTHROUGH_NS       = 30;
  localparam int WRITE_DATA_SETUP_NS  = 15;
  localparam int WRITE_PULSE_NS       = 20;
  localparam int CONTENTION_SETTLE_NS = 20;
  localparam int PRIORITY_SETUP_NS    = 5;
  localparam int FLAG_UPDATE_PULSE_NS = 10;
  localparam int FLAG_WRITE_TO_READ_NS = 5;

  // least time in ns rounded up to whole cycles, never below one
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // derived cycle counts
  localparam int WRITE_CYC      = imax(cyc_min(WRITE_PULSE_NS),
                                       cyc_min(WRITE_DATA_SETUP_NS));
  localparam int SETTLE_CYC     = cyc_min(CONTENTION_SETTLE_NS);
  localparam int PRIO_SETUP_CYC = cyc_min(PRIORITY_SETUP_NS);
  localparam int MEM_READ_CYC   = imax(imax(cyc_min(SELECT_ACCESS_NS),
                                            cyc_min(OE_ACCESS_NS)),
                                       cyc_min(FLOWTHROUGH_NS));
  localparam int TOKEN_READ_CYC = cyc_min(FLAG_WRITE_TO_READ_NS
                                          + OE_ACCESS_NS);
  localparam int FLAG_GAP_CYC   = cyc_min(FLAG_UPDATE_PULSE_NS);
  localparam int PLAIN_GAP_CYC  = 1;

  // widths
  localparam int TIMER_W        = 4;
  localparam int TOKEN_ADDR_W   = 3;
  localparam int TOKEN_DATA_BIT = 0;

  // user commands
  typedef enum logic [2:0] {
    OP_MEM_READ,
    OP_MEM_WRITE,
    OP_TOKEN_READ,
    OP_TOKEN_WRITE,
    OP_TOKEN_TAKE,
    OP_MAIL_POST,
    OP_MAIL_FETCH
  } dprm_op_t;

  // controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_WRITE,
    ST_GAP,
    ST_READ
  } dprm_state_t;

endpackage

//--- hdl/dprm_wait_timer.sv
// Purpose: down counter that times pin phases of the host controller
// Assumes: load_value is at least one
// Notes:   expired rises load_value cycles after the load cycle
`timescale 1ns/10ps
`default_nettype none
module dprm_wait_timer
#(
  parameter int W = 4
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  // status
  output logic              expired
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // load wins over counting so a reload always restarts the full phase
  always_comb
  begin
    count_next = count_reg;
    if (load)
      count_next = load_value - W'(1);
    else if (count_reg != '0)
      count_next = count_reg - W'(1);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  assign expired = (count_reg == '0);

endmodule
`default_nettype wire

//--- hdl/dprm_host.sv
// Purpose: host controller driving one port of an asynchronous dual-port
//          ram with mailbox interrupts, contention flag and token latches
// Assumes: device pins are synchronous to clk; role_master mirrors the
//          device's master/slave strap
// Notes:   every pin comes from a flip-flop; phases are timed in cycles
`timescale 1ns/10ps
`default_nettype none
module dprm_host
  import dprm_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int DATA_W  = 8,
  parameter bit IS_LEFT = 1'b1
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // device role strap, high for master
  input  wire logic                  role_master,
  // user command
  input  wire logic                  cmd_valid,
  input  wire dprm_pkg::dprm_op_t    cmd_op,
  input  wire logic [ADDR_W-1:0]     cmd_addr,
  input  wire logic [DATA_W-1:0]     cmd_wdata,
  output logic                       cmd_ready,
  // user answer
  output logic                       resp_valid,
  output logic [DATA_W-1:0]          resp_rdata,
  output logic                       mail_pending,
  // device port pins
  output logic                       select_n,
  output logic                       token_select_n,
  output logic                       write_n,
  output logic                       out_en_n,
  output logic [ADDR_W-1:0]          addr,
  output logic [DATA_W-1:0]          data_out,
  output logic                       data_oe,
  input  wire logic [DATA_W-1:0]     data_in,
  input  wire logic                  contention_n,
  input  wire logic                  mail_int_n
);
  import dprm_pkg::*;

  dprm_state_t         state_reg,  state_next;
  dprm_op_t            op_reg,     op_next;
  logic                sel_n_reg,  sel_n_next;
  logic                tok_n_reg,  tok_n_next;
  logic                wr_n_reg,   wr_n_next;
  logic                oe_n_reg,   oe_n_next;
  logic [ADDR_W-1:0]   addr_reg,   addr_next;
  logic [DATA_W-1:0]   dout_reg,   dout_next;
  logic                doe_reg,    doe_next;
  logic                ready_reg,  ready_next;
  logic                rvalid_reg, rvalid_next;
  logic [DATA_W-1:0]   rdata_reg,  rdata_next;
  logic                mail_reg,   mail_next;
  logic                tmr_load;
  logic [TIMER_W-1:0]  tmr_value;
  logic                tmr_expired;

  // mailbox address owned by the right or the left port
  function automatic logic [ADDR_W-1:0] mbox_addr(input logic right_owner);
    return right_owner ? {ADDR_W{1'b1}} : {{(ADDR_W-1){1'b1}}, 1'b0};
  endfunction

  function automatic logic is_token_op(input dprm_op_t op);
    return (op == OP_TOKEN_READ) || (op == OP_TOKEN_WRITE)
           || (op == OP_TOKEN_TAKE);
  endfunction

  function automatic logic is_write_op(input dprm_op_t op);
    return (op == OP_MEM_WRITE) || (op == OP_TOKEN_WRITE)
           || (op == OP_TOKEN_TAKE) || (op == OP_MAIL_POST);
  endfunction

  dprm_wait_timer #(.W(TIMER_W)) u_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .load       (tmr_load),
    .load_value (tmr_value),
    .expired    (tmr_expired)
  );

  // next state of the pin sequencer
  always_comb
  begin
    state_next  = state_reg;
    op_next     = op_reg;
    sel_n_next  = sel_n_reg;
    tok_n_next  = tok_n_reg;
    wr_n_next   = wr_n_reg;
    oe_n_next   = oe_n_reg;
    addr_next   = addr_reg;
    dout_next   = dout_reg;
    doe_next    = doe_reg;
    ready_next  = ready_reg;
    rvalid_next = 1'b0;
    rdata_next  = rdata_reg;
    mail_next   = !mail_int_n;
    tmr_load    = 1'b0;
    tmr_value   = TIMER_W'(PLAIN_GAP_CYC);
    case (state_reg)
      ST_IDLE:
      begin
        if (cmd_valid && ready_reg)
        begin
          op_next    = cmd_op;
          ready_next = 1'b0;
          dout_next  = cmd_wdata;
          addr_next  = cmd_addr;
          if (cmd_op == OP_MAIL_POST)
            addr_next = mbox_addr(IS_LEFT);
          else if (cmd_op == OP_MAIL_FETCH)
            addr_next = mbox_addr(!IS_LEFT);
          else if (is_token_op(cmd_op))
            addr_next = {{(ADDR_W-TOKEN_ADDR_W){1'b0}},
                         cmd_addr[TOKEN_ADDR_W-1:0]};
          if (cmd_op == OP_TOKEN_TAKE)
            dout_next = '0;
          else if (cmd_op == OP_TOKEN_WRITE)
            dout_next = {DATA_W{cmd_wdata[TOKEN_DATA_BIT]}};
          // never both selects at once
          if (is_token_op(cmd_op))
            tok_n_next = 1'b0;
          else
            sel_n_next = 1'b0;
          tmr_load = 1'b1;
          if (is_write_op(cmd_op))
          begin
            doe_next   = 1'b1;
            state_next = ST_SETTLE;
            // slave waits out the master's arbitration
            tmr_value  = role_master ? TIMER_W'(PRIO_SETUP_CYC)
                                     : TIMER_W'(SETTLE_CYC);
          end
          else
          begin
            oe_n_next  = 1'b0;
            state_next = ST_READ;
            tmr_value  = is_token_op(cmd_op) ? TIMER_W'(TOKEN_READ_CYC)
                                             : TIMER_W'(MEM_READ_CYC);
          end
        end
      end
      ST_SETTLE:
      begin
        // a slave never opens a strobe while contention is shown
        if (tmr_expired && (role_master || contention_n))
        begin
          wr_n_next  = 1'b0;
          tmr_load   = 1'b1;
          tmr_value  = TIMER_W'(WRITE_CYC);
          state_next = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        // a lost arbitration blocks the write, so stretch the strobe
        if (!contention_n)
        begin
          tmr_load  = 1'b1;
          tmr_value = TIMER_W'(WRITE_CYC);
        end
        else if (tmr_expired)
        begin
          wr_n_next  = 1'b1;
          sel_n_next = 1'b1;
          tok_n_next = 1'b1;
          tmr_load   = 1'b1;
          tmr_value  = is_token_op(op_reg) ? TIMER_W'(FLAG_GAP_CYC)
                                           : TIMER_W'(PLAIN_GAP_CYC);
          state_next = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // data stays one cycle past the strobe for hold time
        doe_next = 1'b0;
        if (tmr_expired)
        begin
          if (op_reg == OP_TOKEN_TAKE)
          begin
            tok_n_next = 1'b0;
            oe_n_next  = 1'b0;
            tmr_load   = 1'b1;
            tmr_value  = TIMER_W'(TOKEN_READ_CYC);
            state_next = ST_READ;
          end
          else
          begin
            rvalid_next = 1'b1;
            ready_next  = 1'b1;
            state_next  = ST_IDLE;
          end
        end
      end
      ST_READ:
      begin
        // data is undefined until flowthrough after contention ends
        if (!is_token_op(op_reg) && !contention_n)
        begin
          tmr_load  = 1'b1;
          tmr_value = TIMER_W'(MEM_READ_CYC);
        end
        else if (tmr_expired)
        begin
          rdata_next = data_in;
          sel_n_next = 1'b1;
          tok_n_next = 1'b1;
          oe_n_next  = 1'b1;
          if (op_reg == OP_TOKEN_TAKE && data_in[TOKEN_DATA_BIT])
          begin
            // other port owns it: pause, then poll again
            tmr_load   = 1'b1;
            tmr_value  = TIMER_W'(FLAG_GAP_CYC);
            state_next = ST_GAP;
          end
          else
          begin
            rvalid_next = 1'b1;
            ready_next  = 1'b1;
            state_next  = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  // register stage; strobes and selects idle high, data pins released
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg  <= ST_IDLE;
      op_reg     <= OP_MEM_READ;
      sel_n_reg  <= 1'b1;
      tok_n_reg  <= 1'b1;
      wr_n_reg   <= 1'b1;
      oe_n_reg   <= 1'b1;
      addr_reg   <= '0;
      dout_reg   <= '0;
      doe_reg    <= 1'b0;
      ready_reg  <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      mail_reg   <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      op_reg     <= op_next;
      sel_n_reg  <= sel_n_next;
      tok_n_reg  <= tok_n_next;
      wr_n_reg   <= wr_n_next;
      oe_n_reg   <= oe_n_next;
      addr_reg   <= addr_next;
      dout_reg   <= dout_next;
      doe_reg    <= doe_next;
      ready_reg  <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      mail_reg   <= mail_next;
    end
  end

  // outputs straight from flip-flops
  assign cmd_ready      = ready_reg;
  assign resp_valid     = rvalid_reg;
  assign resp_rdata     = rdata_reg;
  assign mail_pending   = mail_reg;
  assign select_n       = sel_n_reg;
  assign token_select_n = tok_n_reg;
  assign write_n        = wr_n_reg;
  assign out_en_n       = oe_n_reg;
  assign addr           = addr_reg;
  assign data_out       = dout_reg;
  assign data_oe        = doe_reg;

  // helper counters of strobe and enable lengths, read only by checks
  logic [7:0] wlow_cnt;
  logic [7:0] rlow_cnt;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wlow_cnt <= '0;
      rlow_cnt <= '0;
    end
    else
    begin
      wlow_cnt <= wr_n_reg ? 8'h00 : wlow_cnt + 8'h01;
      rlow_cnt <= oe_n_reg ? 8'h00 : rlow_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_write_data_held: assert property (
    !wr_n_reg |-> doe_reg && $stable(dout_reg))
    else $error("write data not held during strobe");
  a_write_pulse_len: assert property (
    $rose(wr_n_reg) |-> wlow_cnt >= WRITE_CYC)
    else $error("write strobe shorter than setup");
  a_mem_read_wait: assert property (
    ($rose(oe_n_reg) && $past(!sel_n_reg)) |-> rlow_cnt >= MEM_READ_CYC)
    else $error("memory read sampled too early");
  a_read_enables: assert property (
    $rose(rvalid_reg) && state_reg == ST_IDLE && !is_write_op(op_reg)
      |-> $past(!oe_n_reg) && ($past(!sel_n_reg)
          || $past(!tok_n_reg)))
    else $error("read answered without both enables");
  a_select_exclusive: assert property (
    !(!sel_n_reg && !tok_n_reg))
    else $error("port and token select both low");
  a_slave_write_hold: assert property (
    (state_reg == ST_SETTLE && !role_master && !contention_n) |=> wr_n_reg)
    else $error("slave strobe opened under contention");
  a_token_gap_len: assert property (
    (!tok_n_reg && !oe_n_reg && op_reg == OP_TOKEN_TAKE)
      |-> $past(tok_n_reg) || $past(!oe_n_reg))
    else $error("token read without a release gap");
  a_token_addr_low: assert property (
    !tok_n_reg |-> addr_reg[ADDR_W-1:TOKEN_ADDR_W] == '0)
    else $error("token access with high address bits");
  a_mail_post_addr: assert property (
    (!wr_n_reg && op_reg == OP_MAIL_POST) |-> addr_reg == mbox_addr(IS_LEFT))
    else $error("mail post to wrong mailbox");

  c_mem_write: cover property (
    state_reg == ST_GAP && op_reg == OP_MEM_WRITE ##1 rvalid_reg);
  c_token_poll: cover property (
    state_reg == ST_READ && op_reg == OP_TOKEN_TAKE ##1 state_reg == ST_GAP);
  c_mail_fetch: cover property (rvalid_reg && op_reg == OP_MAIL_FETCH);
  c_read_contended: cover property (state_reg == ST_READ && !contention_n);

endmodule
`default_nettype wire

//--- verif/dprm_dev_model.sv
// Purpose: behavioural model of the dual-port ram device, left port pins
//          facing the host, right side worked by bench inputs
// Assumes: one host on the left port; the right side is abstract
// Notes:   released data pins show the inverse of the last word driven
`timescale 1ns/10ps
`default_nettype none
module dprm_dev_model
  import dprm_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
)
(
  // left port pins
  input  wire logic              select_n,
  input  wire logic              token_select_n,
  input  wire logic              write_n,
  input  wire logic              out_en_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe,
  output logic [DATA_W-1:0]      data_in,
  output logic                   contention_n,
  output logic                   mail_int_n,
  // right side, worked by the bench
  input  wire logic              far_busy,
  input  wire logic              slave_mode,
  input  wire logic              far_post,
  input  wire logic [DATA_W-1:0] far_data,
  input  wire logic              far_tok_wr,
  input  wire logic [2:0]        far_tok_idx,
  input  wire logic              far_tok_bit,
  // observation
  output logic                   right_int_n,
  output logic [7:0]             proto_err
);
  localparam logic [ADDR_W-1:0] RIGHT_BOX = '1;
  localparam logic [ADDR_W-1:0] LEFT_BOX  = RIGHT_BOX - 1'b1;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0]        own [2];
  logic [7:0]        req [2];
  logic [DATA_W-1:0] wr_hold;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] last_q;
  logic              rd_on;
  logic              rd_ok;
  // selects seen when the strobe opened; they may drop with its rise
  logic              wr_open;
  logic              wr_sel_n;
  logic              wr_tok_n;
  logic              left_int;
  logic              right_int;
  realtime           t_tok_wend;

  initial
  begin
    own = '{8'h00, 8'h00};
    req = '{8'h00, 8'h00};
    {left_int, right_int, rd_ok} = 3'h0;
    last_q = '0;
    wr_open = 1'b0;
    proto_err = 8'h00;
    t_tok_wend = -1000.0;
  end

  // one side at a time, so simultaneous requests still give one owner
  task automatic tok_write(input logic s, input logic [2:0] i,
                           input logic b);
    if (!b)
    begin
      if (own[!s][i])
        req[s][i] = 1'b1;
      else
        own[s][i] = 1'b1;
    end
    else if (own[s][i])
    begin
      own[s][i] = 1'b0;
      own[!s][i] = req[!s][i];
      req[!s][i] = 1'b0;
    end
    else
      req[s][i] = 1'b0;
  endtask

  // strobe fall: note data, flag illegal selects and slave writes in busy
  always @(negedge write_n)
  begin
    wr_hold = data_out;
    wr_sel_n = select_n;
    wr_tok_n = token_select_n;
    wr_open = 1'b1;
    if (!select_n && !token_select_n)
      proto_err++;
    if (slave_mode && !contention_n && !select_n)
      proto_err++;
  end

  // strobe rise ends the write; a contended write is blocked; the
  // release of the strobe out of reset opens no write
  always @(posedge write_n)
  begin
    if (wr_open === 1'b1)
    begin
      wr_open = 1'b0;
      if (!data_oe || data_out !== wr_hold)
        proto_err++;
      if (!wr_sel_n && wr_tok_n && contention_n)
      begin
        mem[addr] = data_out;
        if (addr == RIGHT_BOX)
          right_int = 1'b1;
      end
      else if (!wr_tok_n && wr_sel_n)
      begin
        tok_write(1'b0, addr[2:0], data_out[0]);
        t_tok_wend = $realtime;
      end
    end
  end

  always @(posedge far_tok_wr)
    tok_write(1'b1, far_tok_idx, far_tok_bit);

  // far port writes the left mailbox
  always @(posedge far_post)
  begin
    mem[LEFT_BOX] = far_data;
    left_int = 1'b1;
  end

  assign rd_on = !out_en_n && write_n
                 && (select_n != token_select_n);

  // word is latched at read start, valid one access time later
  always @(rd_on)
  begin
    rd_ok = 1'b0;
    if (rd_on)
    begin
      if (!token_select_n)
      begin
        if ($realtime - t_tok_wend < FLAG_UPDATE_PULSE_NS)
          proto_err++;
        rd_word = {DATA_W{~own[0][addr[2:0]]}};
      end
      else
      begin
        rd_word = mem[addr];
        if (addr == LEFT_BOX && contention_n)
          left_int = 1'b0;
      end
      #(imax(SELECT_ACCESS_NS, OE_ACCESS_NS));
      rd_ok = rd_on;
    end
  end

  always @(posedge rd_ok)
    last_q = rd_word;

  assign data_in      = rd_ok ? rd_word : ~last_q;
  assign contention_n = ~far_busy;
  assign mail_int_n   = ~left_int;
  assign right_int_n  = ~right_int;
endmodule
`default_nettype wire

//--- verif/dprm_host_tb.sv
// Purpose: self-checking bench for the left-port host controller
// Assumes: device model on the pins, right side driven from here
// Notes:   inputs change at the falling edge only
`timescale 1ns/10ps
`default_nettype none
module dprm_host_tb;
  import dprm_pkg::*;
  logic clk, reset_n, role_master, cmd_valid, cmd_ready, resp_valid;
  logic mail_pending, select_n, token_select_n, write_n, out_en_n;
  logic data_oe, contention_n, mail_int_n, right_int_n, far_busy;
  logic slave_mode, far_post, far_tok_wr, far_tok_bit;
  logic [2:0]  far_tok_idx;
  logic [15:0] cmd_addr, addr;
  logic [7:0]  cmd_wdata, resp_rdata, data_out, data_in, far_data;
  logic [7:0]  proto_err, rd;
  dprm_op_t    cmd_op;
  int          error_cnt, compares, cyc;

  dprm_host #(.ADDR_W(16), .DATA_W(8), .IS_LEFT(1'b1)) dut_u (
    .clk(clk), .reset_n(reset_n), .role_master(role_master),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .mail_pending(mail_pending), .select_n(select_n),
    .token_select_n(token_select_n), .write_n(write_n),
    .out_en_n(out_en_n), .addr(addr), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .contention_n(contention_n),
    .mail_int_n(mail_int_n));

  dprm_dev_model #(.ADDR_W(16), .DATA_W(8)) dev_u (
    .select_n(select_n), .token_select_n(token_select_n),
    .write_n(write_n), .out_en_n(out_en_n), .addr(addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .contention_n(contention_n), .mail_int_n(mail_int_n),
    .far_busy(far_busy), .slave_mode(slave_mode), .far_post(far_post),
    .far_data(far_data), .far_tok_wr(far_tok_wr),
    .far_tok_idx(far_tok_idx), .far_tok_bit(far_tok_bit),
    .right_int_n(right_int_n), .proto_err(proto_err));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t data %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask

  // one command; called and left at a falling edge; n counts the wait
  task automatic do_cmd(input dprm_op_t op, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output int n);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    chk_flag(cmd_ready, 1'b1);
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk_flag(resp_valid, 1'b1);
    q = resp_rdata;
  endtask

  // back-to-back writes then reads, edges of the address range
  task automatic sc_mem;
    logic [15:0] at [3] = '{16'h0000, 16'h0001, 16'hFFFD};
    logic [7:0]  dt [3] = '{8'h5A, 8'hA5, 8'h3C};
    foreach (at[i])
      do_cmd(OP_MEM_WRITE, at[i], dt[i], rd, cyc);
    foreach (at[i])
    begin
      do_cmd(OP_MEM_READ, at[i], 8'h00, rd, cyc);
      chk_data(rd, dt[i]);
    end
  endtask

  // mailbox both ways; reading the other box leaves ours pending
  task automatic sc_mail;
    far_data = 8'h77;
    far_post = 1'b1;
    repeat (3) @(negedge clk);
    far_post = 1'b0;
    chk_flag(mail_pending, 1'b1);
    do_cmd(OP_MAIL_POST, 16'h0000, 8'h42, rd, cyc);
    chk_flag(right_int_n, 1'b0);
    do_cmd(OP_MEM_READ, 16'hFFFF, 8'h00, rd, cyc);
    chk_data(rd, 8'h42);
    chk_flag(mail_pending, 1'b1);
    chk_flag(right_int_n, 1'b0);
    do_cmd(OP_MAIL_FETCH, 16'h1234, 8'h00, rd, cyc);
    chk_data(rd, 8'h77);
    repeat (2) @(negedge clk);
    chk_flag(mail_pending, 1'b0);
  endtask

  // token: read through high address bits, take while held, release
  task automatic sc_token;
    far_tok_idx = 3'h5;
    far_tok_bit = 1'b0;
    far_tok_wr = 1'b1;
    @(negedge clk);
    far_tok_wr = 1'b0;
    do_cmd(OP_TOKEN_READ, 16'hFFF5, 8'h00, rd, cyc);
    chk_data(rd, 8'hFF);
    fork
      do_cmd(OP_TOKEN_TAKE, 16'h0005, 8'h00, rd, cyc);
      begin
        repeat (20) @(negedge clk);
        far_tok_bit = 1'b1;
        far_tok_wr = 1'b1;
      end
    join
    far_tok_wr = 1'b0;
    chk_flag(cyc >= 15, 1'b1);
    chk_data(rd, 8'h00);
    do_cmd(OP_TOKEN_WRITE, 16'h0002, 8'hFE, rd, cyc);
    do_cmd(OP_TOKEN_READ, 16'h0002, 8'h00, rd, cyc);
    chk_data(rd, 8'h00);
    do_cmd(OP_TOKEN_WRITE, 16'h0002, 8'h01, rd, cyc);
    do_cmd(OP_TOKEN_READ, 16'h0002, 8'h00, rd, cyc);
    chk_data(rd, 8'hFF);
  endtask

  // a write under busy must wait it out, as master and as slave
  task automatic sc_busy;
    for (int m = 1; m >= 0; m--)
    begin
      role_master = m[0];
      slave_mode = !m[0];
      far_busy = 1'b1;
      fork
        do_cmd(OP_MEM_WRITE, 16'h0010, 8'h90 + m[7:0], rd, cyc);
        begin
          repeat (10) @(negedge clk);
          far_busy = 1'b0;
        end
      join
      chk_flag(cyc >= 9, 1'b1);
      // a read under busy must wait until busy lifts
      far_busy = 1'b1;
      fork
        do_cmd(OP_MEM_READ, 16'h0010, 8'h00, rd, cyc);
        begin
          repeat (6) @(negedge clk);
          far_busy = 1'b0;
        end
      join
      chk_flag(cyc >= 5, 1'b1);
      chk_data(rd, 8'h90 + m[7:0]);
    end
  endtask

  // cut a hang short well past the expected run length
  initial
  begin
    #(5000 * 50);
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    {reset_n, cmd_valid, far_busy, slave_mode, far_post} = 5'h00;
    {far_tok_wr, far_tok_bit} = 2'h0;
    role_master = 1'b1;
    cmd_op = OP_MEM_READ;
    {cmd_addr, cmd_wdata, far_data, far_tok_idx} = '0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    sc_mem();
    sc_mail();
    sc_token();
    sc_busy();
    chk_data(proto_err, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
